// File: rtl/its_command_error_reporting.sv
// Error detection and syndrome record of the interrupt translation service, with an APB register slave.
//
// How it works
// - Invalidate-all on a lost virtual PE: syndrome 0x12d33, kind 1, no stall, PE id.
// - Device beyond range: 0x10301, enable gated, optional stall, device id bits 31:0.
// - Unmapped device: 0x10304, enable gated, device id in bits 23:0 when not stalled.
// - Event beyond map size: 0x10305, bit 50 OR of event 31:20, event, device fields.
// - Unmapped event: 0x10307, enable gated, same event and device field layout.
// - Unsupported event entry: 0x10310, collection id in bits 13:0 when not stalled.
// - Target with message interrupts disabled: 0x10323, kind 1, no stall, target recorded.
// - Target PE on offline chip: 0x10325, kind 1, no stall, target recorded.
// - Physical number beyond target width: 0x10326, no stall, interrupt dropped, id recorded.
// - Virtual number beyond table size: 0x12426, chip, virtual bits, PE id recorded.
// - Virtual PE unmapped: 0x12430, virtual bits and PE id recorded.
// - Virtual PE outside configured range: 0x12431, virtual bits and PE id recorded.
// - Virtual PE on offline chip: 0x12425, chip, virtual bits, PE id recorded.
// - Virtual number range failure on remote chip: distinct 0x12432, same three fields.
// - Lost virtual PE: 0x12433, kind 1, no stall.
// - Map command PE id over limits: 0x12903, kind 0, stalls, records zero.
// - Map doorbell over maximum or below 8192 except 1023: 0x12904, stalls.
// - Map table size over maximum: 0x12910, stalls, records zero.
// - Map target index out of range: 0x12920, kind 1, no stall, records zero.
// - Debug data of the five gated translation checks only for doorbell writes, never for raise commands.
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps

module its_command_error_reporting #(
   parameter logic [15:0]                 VPE_HW_MAX = 16'hffff,
   parameter logic [31:0]                 DB_HW_MAX  = 32'h0000_ffff,
   parameter logic [5:0]                  VPT_HW_MAX = 6'h10,
   parameter logic [15:0]                 RD_COUNT   = 16'h0008
) (
   input  wire logic                      clock_i,
   input  wire logic                      sys_rst_i,
   input  wire its_err_pkg::apb_req_t     apb_i,
   output its_err_pkg::apb_rsp_t          apb_o,
   input  wire its_err_pkg::trans_event_t event_i,
   input  wire its_err_pkg::map_cmd_t     map_i,
   output logic                           stall_o,
   output logic                           record_valid_o,
   output logic                           drop_o
);
   import its_err_pkg::*;

   apb_rsp_t           apb_rsp_r;
   logic [1:0]         ctrl_r;
   logic [VPE_W-1:0]   vpe_limit_r;
   rec_state_t         rec_state_r;
   rec_state_t         rec_state_nxt;
   logic [SYND_W-1:0]  syndrome_r;
   logic [EXTRA_W-1:0] extra_r;
   logic               kind_r;
   logic               overflow_r;
   logic               stall_r;
   logic               drop_r;

   logic               bus_access;
   logic               bus_write;
   logic               addr_hit;
   logic [31:0]        read_word;
   logic               clear_record;
   logic               clear_overflow;
   logic               map_hit;
   err_kind_t          map_kind;
   logic               event_ok;
   logic               cand_valid;
   err_kind_t          cand_kind;
   logic               cand_stall;
   logic [EXTRA_W-1:0] cand_extra;
   logic               capture;
   logic               lost_event;

   // Builds the extra word for a translation or invalidate event.
   function automatic logic [EXTRA_W-1:0] event_extra(input trans_event_t ev, input logic stalled);
      logic [EXTRA_W-1:0] w;
      w = '0;
      case (ev.kind)
         vinvalidate_all_lost_vpe_error: begin
            w[VPE_W-1:0] = ev.virtual_pe_identifier;
         end
         translate_device_range_error: begin
            w[31:0] = ev.device_identifier;
         end
         translate_unmapped_device_error: begin
            w[EXT_DEV_W-1:0] = ev.device_identifier[EXT_DEV_W-1:0];
         end
         translate_event_range_error, translate_unmapped_event_error: begin
            w[EXT_EVTHI_BIT] = |ev.event_identifier[31:EVT_HI_LSB];
            w[EXT_EVT_LSB+EXT_EVT_W-1:EXT_EVT_LSB] = ev.event_identifier[EXT_EVT_W-1:0];
            w[EXT_DEV_W-1:0] = ev.device_identifier[EXT_DEV_W-1:0];
         end
         translate_invalid_entry_error: begin
            w[EXT_COLL_W-1:0] = ev.collection_id;
         end
         translate_target_disabled_error, translate_chip_offline_error: begin
            w[31:0] = ev.redistributor;
         end
         translate_physical_range_error: begin
            w[31:0] = ev.physical_id;
         end
         virtual_number_range_error, virtual_pe_chip_offline_error, virtual_number_range_remote_error: begin
            w[CHIP_W+VINT_W+VPE_W-1:0] = {ev.chip_number, ev.virtual_interrupt_bits,
                                          ev.virtual_pe_identifier};
         end
         virtual_pe_unmapped_error, virtual_pe_range_error, virtual_pe_lost_error: begin
            w[VINT_W+VPE_W-1:0] = {ev.virtual_interrupt_bits, ev.virtual_pe_identifier};
         end
         default: begin
            w = '0;
         end
      endcase
      // A raise command or a stalled stream leaves no debug data for the gated checks.
      if (is_gated(ev.kind) && (stalled || !ev.from_doorbell)) begin
         w = '0;
      end
      event_extra = w;
   endfunction

   // Bus decode. The access phase always takes two cycles: pready rises one edge after penable.
   assign bus_access = apb_i.psel && apb_i.penable && apb_rsp_r.pready;
   assign bus_write  = bus_access && apb_i.pwrite && addr_hit;

   always_comb begin
      addr_hit  = 1'b1;
      read_word = '0;
      case (apb_i.paddr)
         OFF_CTRL: begin
            read_word[1:0] = ctrl_r;
         end
         OFF_STATUS: begin
            read_word[ST_VALID_BIT] = (rec_state_r != rec_empty);
            read_word[ST_KIND_BIT]  = kind_r;
            read_word[ST_STALL_BIT] = stall_r;
            read_word[ST_OVF_BIT]   = overflow_r;
         end
         OFF_SYNDROME: begin
            read_word[SYND_W-1:0] = syndrome_r;
         end
         OFF_EXTRA_LO: begin
            read_word = extra_r[31:0];
         end
         OFF_EXTRA_HI: begin
            read_word = extra_r[EXTRA_W-1:32];
         end
         OFF_VPE_LIMIT: begin
            read_word[VPE_W-1:0] = vpe_limit_r;
         end
         default: begin
            addr_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         apb_rsp_r <= '0;
      end else begin
         apb_rsp_r.pready  <= apb_i.psel && apb_i.penable && !apb_rsp_r.pready;
         apb_rsp_r.prdata  <= read_word;
         apb_rsp_r.pslverr <= apb_i.psel && apb_i.penable && !apb_rsp_r.pready && !addr_hit;
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_r <= CTRL_RST;
      end else if (bus_write && (apb_i.paddr == OFF_CTRL)) begin
         ctrl_r <= apb_i.pwdata[1:0];
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         vpe_limit_r <= VPE_LIMIT_RST;
      end else if (bus_write && (apb_i.paddr == OFF_VPE_LIMIT)) begin
         vpe_limit_r <= apb_i.pwdata[VPE_W-1:0];
      end
   end

   assign clear_record   = bus_write && (apb_i.paddr == OFF_STATUS) && apb_i.pwdata[ST_VALID_BIT];
   assign clear_overflow = bus_write && (apb_i.paddr == OFF_STATUS) && apb_i.pwdata[ST_OVF_BIT];

   // First checks of a virtual PE map command, in a fixed order of precedence.
   always_comb begin
      map_hit  = 1'b0;
      map_kind = map_vpe_id_range_error;
      if (map_i.valid) begin
         if ((map_i.virtual_pe_identifier > VPE_HW_MAX) || (map_i.virtual_pe_identifier > vpe_limit_r)) begin
            map_hit  = 1'b1;
            map_kind = map_vpe_id_range_error;
         end else if ((map_i.doorbell_id > DB_HW_MAX) ||
                      ((map_i.doorbell_id < DB_LOW_LIMIT) && (map_i.doorbell_id != DB_EXEMPT))) begin
            map_hit  = 1'b1;
            map_kind = map_doorbell_range_error;
         end else if (map_i.virtual_pending_table_size > VPT_HW_MAX) begin
            map_hit  = 1'b1;
            map_kind = map_table_size_error;
         end else if (map_i.redistributor_index >= RD_COUNT) begin
            map_hit  = 1'b1;
            map_kind = map_target_range_error;
         end
      end
   end

   // A gated translation check is ignored outright while the report enable is low.
   assign event_ok = event_i.valid && (!is_gated(event_i.kind) || ctrl_r[CTRL_REN_BIT]);

   // Map errors win a tie because three of them stall the command stream.
   always_comb begin
      cand_valid = map_hit || event_ok;
      cand_kind  = map_hit ? map_kind : event_i.kind;
      cand_stall = always_stalls(cand_kind) ||
                   (is_gated(cand_kind) && ctrl_r[CTRL_STALL_BIT]);
      if (map_hit) begin
         cand_extra = '0;
      end else begin
         cand_extra = event_extra(event_i, cand_stall);
      end
   end

   // Only one record exists; a clear in the same cycle as a new error lets the new one in.
   assign capture    = cand_valid && ((rec_state_r == rec_empty) || clear_record);
   assign lost_event = (cand_valid && !capture) || (map_hit && event_ok);

   always_comb begin
      rec_state_nxt = rec_state_r;
      if (capture) begin
         rec_state_nxt = cand_stall ? rec_stalled : rec_held;
      end else if (clear_record) begin
         rec_state_nxt = rec_empty;
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rec_state_r <= rec_empty;
      end else begin
         case (rec_state_nxt)
            rec_empty:   rec_state_r <= rec_empty;
            rec_held:    rec_state_r <= rec_held;
            rec_stalled: rec_state_r <= rec_stalled;
            default:     rec_state_r <= rec_empty;
         endcase
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         syndrome_r <= '0;
         extra_r    <= '0;
         kind_r     <= 1'b0;
      end else if (capture) begin
         syndrome_r <= syndrome_of(cand_kind);
         extra_r    <= cand_extra;
         kind_r     <= error_kind_of(cand_kind);
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         overflow_r <= 1'b0;
      end else if (lost_event) begin
         overflow_r <= 1'b1;
      end else if (clear_overflow) begin
         overflow_r <= 1'b0;
      end
   end

   // The stall is released only by software clearing the record.
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         stall_r <= 1'b0;
      end else begin
         stall_r <= (rec_state_nxt == rec_stalled);
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         drop_r <= 1'b0;
      end else begin
         drop_r <= event_ok && (event_i.kind == translate_physical_range_error);
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         record_valid_o <= 1'b0;
      end else begin
         record_valid_o <= (rec_state_nxt != rec_empty);
      end
   end

   assign apb_o   = apb_rsp_r;
   assign stall_o = stall_r;
   assign drop_o  = drop_r;

endmodule

// File: rtl/its_err_pkg.sv
// Package with the constants, types and lookup functions of the translation error reporting block.
package its_err_pkg;

   localparam int CHIP_W  = 4;
   localparam int VPE_W   = 16;
   localparam int VINT_W  = 16;
   localparam int SYND_W  = 17;
   localparam int EXTRA_W = 64;
   localparam int ADDR_W  = 12;
   localparam int VPT_W   = 6;

   // Register byte offsets.
   localparam logic [ADDR_W-1:0] OFF_CTRL      = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_STATUS    = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_SYNDROME  = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_EXTRA_LO  = 12'h00c;
   localparam logic [ADDR_W-1:0] OFF_EXTRA_HI  = 12'h010;
   localparam logic [ADDR_W-1:0] OFF_VPE_LIMIT = 12'h014;

   // Field positions.
   localparam int CTRL_REN_BIT   = 0;
   localparam int CTRL_STALL_BIT = 1;
   localparam int ST_VALID_BIT   = 0;
   localparam int ST_KIND_BIT    = 1;
   localparam int ST_STALL_BIT   = 2;
   localparam int ST_OVF_BIT     = 3;
   localparam int EXT_EVTHI_BIT  = 50;
   localparam int EXT_EVT_LSB    = 24;
   localparam int EXT_EVT_W      = 20;
   localparam int EXT_DEV_W      = 24;
   localparam int EXT_COLL_W     = 14;
   localparam int EVT_HI_LSB     = 20;

   // Reset values.
   localparam logic [1:0]       CTRL_RST      = 2'h1;
   localparam logic [VPE_W-1:0] VPE_LIMIT_RST = 16'hffff;

   // Doorbell limits for the map command.
   localparam logic [31:0] DB_LOW_LIMIT = 32'h0000_2000;
   localparam logic [31:0] DB_EXEMPT    = 32'h0000_03ff;

   // Syndrome encodings.
   localparam logic [SYND_W-1:0] SYN_VINVALL_LOST  = 17'h12d33;
   localparam logic [SYND_W-1:0] SYN_DEV_RANGE     = 17'h10301;
   localparam logic [SYND_W-1:0] SYN_DEV_UNMAPPED  = 17'h10304;
   localparam logic [SYND_W-1:0] SYN_EVT_RANGE     = 17'h10305;
   localparam logic [SYND_W-1:0] SYN_EVT_UNMAPPED  = 17'h10307;
   localparam logic [SYND_W-1:0] SYN_ENTRY_INVALID = 17'h10310;
   localparam logic [SYND_W-1:0] SYN_TGT_DISABLED  = 17'h10323;
   localparam logic [SYND_W-1:0] SYN_CHIP_OFF      = 17'h10325;
   localparam logic [SYND_W-1:0] SYN_PHYS_RANGE    = 17'h10326;
   localparam logic [SYND_W-1:0] SYN_VNUM_RANGE    = 17'h12426;
   localparam logic [SYND_W-1:0] SYN_VPE_UNMAPPED  = 17'h12430;
   localparam logic [SYND_W-1:0] SYN_VPE_RANGE     = 17'h12431;
   localparam logic [SYND_W-1:0] SYN_VPE_CHIP_OFF  = 17'h12425;
   localparam logic [SYND_W-1:0] SYN_VNUM_REMOTE   = 17'h12432;
   localparam logic [SYND_W-1:0] SYN_VPE_LOST      = 17'h12433;
   localparam logic [SYND_W-1:0] SYN_MAP_VPE       = 17'h12903;
   localparam logic [SYND_W-1:0] SYN_MAP_DOORBELL  = 17'h12904;
   localparam logic [SYND_W-1:0] SYN_MAP_VPT       = 17'h12910;
   localparam logic [SYND_W-1:0] SYN_MAP_TARGET    = 17'h12920;

   typedef enum logic [4:0] {
      vinvalidate_all_lost_vpe_error  = 5'h00,
      translate_device_range_error    = 5'h01,
      translate_unmapped_device_error = 5'h02,
      translate_event_range_error     = 5'h03,
      translate_unmapped_event_error  = 5'h04,
      translate_invalid_entry_error   = 5'h05,
      translate_target_disabled_error = 5'h06,
      translate_chip_offline_error    = 5'h07,
      translate_physical_range_error  = 5'h08,
      virtual_number_range_error      = 5'h09,
      virtual_pe_unmapped_error       = 5'h0a,
      virtual_pe_range_error          = 5'h0b,
      virtual_pe_chip_offline_error   = 5'h0c,
      virtual_number_range_remote_error = 5'h0d,
      virtual_pe_lost_error           = 5'h0e,
      map_vpe_id_range_error          = 5'h10,
      map_doorbell_range_error        = 5'h11,
      map_table_size_error            = 5'h12,
      map_target_range_error          = 5'h13
   } err_kind_t;

   typedef enum logic [1:0] {
      rec_empty   = 2'b00,
      rec_held    = 2'b01,
      rec_stalled = 2'b11
   } rec_state_t;

   typedef struct packed {
      logic                    psel;
      logic                    penable;
      logic                    pwrite;
      logic [ADDR_W-1:0]       paddr;
      logic [31:0]             pwdata;
   } apb_req_t;

   typedef struct packed {
      logic                    pready;
      logic [31:0]             prdata;
      logic                    pslverr;
   } apb_rsp_t;

   typedef struct packed {
      logic                    valid;
      err_kind_t               kind;
      logic                    from_doorbell;
      logic [31:0]             device_identifier;
      logic [31:0]             event_identifier;
      logic [EXT_COLL_W-1:0]   collection_id;
      logic [31:0]             redistributor;
      logic [31:0]             physical_id;
      logic [CHIP_W-1:0]       chip_number;
      logic [VINT_W-1:0]       virtual_interrupt_bits;
      logic [VPE_W-1:0]        virtual_pe_identifier;
   } trans_event_t;

   typedef struct packed {
      logic                    valid;
      logic [VPE_W-1:0]        virtual_pe_identifier;
      logic [31:0]             doorbell_id;
      logic [VPT_W-1:0]        virtual_pending_table_size;
      logic [15:0]             redistributor_index;
   } map_cmd_t;

   function automatic logic [SYND_W-1:0] syndrome_of(input err_kind_t k);
      case (k)
         vinvalidate_all_lost_vpe_error:    syndrome_of = SYN_VINVALL_LOST;
         translate_device_range_error:      syndrome_of = SYN_DEV_RANGE;
         translate_unmapped_device_error:   syndrome_of = SYN_DEV_UNMAPPED;
         translate_event_range_error:       syndrome_of = SYN_EVT_RANGE;
         translate_unmapped_event_error:    syndrome_of = SYN_EVT_UNMAPPED;
         translate_invalid_entry_error:     syndrome_of = SYN_ENTRY_INVALID;
         translate_target_disabled_error:   syndrome_of = SYN_TGT_DISABLED;
         translate_chip_offline_error:      syndrome_of = SYN_CHIP_OFF;
         translate_physical_range_error:    syndrome_of = SYN_PHYS_RANGE;
         virtual_number_range_error:        syndrome_of = SYN_VNUM_RANGE;
         virtual_pe_unmapped_error:         syndrome_of = SYN_VPE_UNMAPPED;
         virtual_pe_range_error:            syndrome_of = SYN_VPE_RANGE;
         virtual_pe_chip_offline_error:     syndrome_of = SYN_VPE_CHIP_OFF;
         virtual_number_range_remote_error: syndrome_of = SYN_VNUM_REMOTE;
         virtual_pe_lost_error:             syndrome_of = SYN_VPE_LOST;
         map_vpe_id_range_error:            syndrome_of = SYN_MAP_VPE;
         map_doorbell_range_error:          syndrome_of = SYN_MAP_DOORBELL;
         map_table_size_error:              syndrome_of = SYN_MAP_VPT;
         map_target_range_error:            syndrome_of = SYN_MAP_TARGET;
         default:                           syndrome_of = '0;
      endcase
   endfunction

   // The five translation checks are gated by the report enable and may stall.
   function automatic logic is_gated(input err_kind_t k);
      is_gated = (k >= translate_device_range_error) && (k <= translate_invalid_entry_error);
   endfunction

   function automatic logic always_stalls(input err_kind_t k);
      always_stalls = (k == map_vpe_id_range_error) || (k == map_doorbell_range_error) ||
                      (k == map_table_size_error);
   endfunction

   function automatic logic error_kind_of(input err_kind_t k);
      error_kind_of = !is_gated(k) && !always_stalls(k);
   endfunction

endpackage

// File: tb/its_err_checker.sv
// Concurrent checks on the ports of the translation error reporting block.
`timescale 1ns/1ps
module its_err_checker #(
   parameter logic [5:0] VPT_HW_MAX = 6'h10
) (
   input wire logic                      clock_i,
   input wire logic                      sys_rst_i,
   input wire its_err_pkg::apb_req_t     apb_i,
   input wire its_err_pkg::apb_rsp_t     apb_o,
   input wire its_err_pkg::trans_event_t event_i,
   input wire its_err_pkg::map_cmd_t     map_i,
   input wire logic                      stall_o,
   input wire logic                      record_valid_o,
   input wire logic                      drop_o
);
   import its_err_pkg::*;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   wire free = !record_valid_o && !map_i.valid;
   wire plain = event_i.valid && (event_i.kind == 5'h00 || event_i.kind inside {[5'h06:5'h0e]});
   wire bad_db = map_i.valid && map_i.doorbell_id < 32'h2000 && map_i.doorbell_id != 32'h3ff;
   wire clr = apb_o.pready && apb_i.pwrite && apb_i.paddr == 12'h004 && apb_i.pwdata[0];
   wire big_vpt = map_i.valid && map_i.virtual_pending_table_size > VPT_HW_MAX;
   apb_one_wait_a: assert property ($rose(apb_i.psel && apb_i.penable) |-> !apb_o.pready ##1 apb_o.pready)
      else $error("APB access not answered after one wait state");
   rec_set_a: assert property (free && plain |=> record_valid_o)
      else $error("error not recorded");
   no_stall_a: assert property (free && plain |=> !stall_o)
      else $error("non stalling error stalled");
   drop_pulse_a: assert property (free && event_i.valid && event_i.kind == 5'h08 |=> drop_o ##1 !drop_o)
      else $error("drop pulse wrong");
   door_stall_a: assert property (!record_valid_o && bad_db |=> record_valid_o && stall_o)
      else $error("bad doorbell did not stall");
   vpt_stall_a: assert property (!record_valid_o && big_vpt |=> record_valid_o && stall_o)
      else $error("table size error did not stall");
   stall_rec_a: assert property (stall_o |-> record_valid_o)
      else $error("stall without record");
   stall_hold_a: assert property (stall_o && !clr |=> stall_o)
      else $error("stall released early");
   rec_hold_a: assert property (record_valid_o && !clr |=> record_valid_o)
      else $error("record lost without clear");
   rec_cause_a: assert property ($rose(record_valid_o) |-> $past(event_i.valid || map_i.valid))
      else $error("record set without cause");
   cover property (free && plain);
   cover property (!record_valid_o && bad_db);
   cover property (drop_o);
endmodule

bind its_command_error_reporting its_err_checker #(.VPT_HW_MAX(VPT_HW_MAX)) i_its_err_checker (
   .clock_i(clock_i), .sys_rst_i(sys_rst_i), .apb_i(apb_i), .apb_o(apb_o), .event_i(event_i),
   .map_i(map_i), .stall_o(stall_o), .record_valid_o(record_valid_o), .drop_o(drop_o));

// File: tb/its_err_partner.sv
// Model of the peripherals and command queue that present errors to the block.
`timescale 1ns/1ps
module its_err_partner (
   input  wire logic                 clock_i,
   output its_err_pkg::trans_event_t event_o,
   output its_err_pkg::map_cmd_t     map_o
);
   import its_err_pkg::*;
   initial begin
      event_o = '0;
      map_o = '0;
   end
   // Idle payloads are inverted so the block cannot lean on stale fields.
   task automatic send(input trans_event_t e, input map_cmd_t m);
      @(posedge clock_i);
      event_o <= e;
      map_o <= m;
      @(posedge clock_i);
      event_o <= {1'b0, ~e[$bits(e)-2:0]};
      map_o <= {1'b0, ~m[$bits(m)-2:0]};
   endtask
endmodule

// File: tb/its_command_error_reporting_tb.sv
// Self-checking bench for the translation error reporting block.
`timescale 1ns/1ps
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin bad_count++; $display("ERROR %0t: got %h exp %h", $time, g, x); end end
module its_command_error_reporting_tb;
   import its_err_pkg::*;
   logic clock_i = 0, sys_rst_i = 1, stall, rec_valid, drop, er;
   apb_req_t req = '0;
   apb_rsp_t rsp;
   trans_event_t ev_w, ev;
   map_cmd_t map_w;
   logic [31:0] q;
   integer seed = 32'hcd0840cd;
   int bad_count = 0, cmp_count = 0;
   logic [16:0] syn[15] = '{17'h12d33, 17'h10301, 17'h10304, 17'h10305, 17'h10307, 17'h10310, 17'h10323,
      17'h10325, 17'h10326, 17'h12426, 17'h12430, 17'h12431, 17'h12425, 17'h12432, 17'h12433};
   logic [15:0] mv[6] = '{16'h20, 16'h1, 16'h1, 16'h1, 16'h10, 16'h1};
   logic [31:0] md[6] = '{32'h2000, 32'h100, 32'h3ff, 32'hffff, 32'h2000, 32'h10000};
   logic [5:0] mt[6] = '{6'h0, 6'h0, 6'h11, 6'h10, 6'h10, 6'h0};
   logic [15:0] mr[6] = '{16'h0, 16'h0, 16'h0, 16'h8, 16'h7, 16'h0};
   logic [16:0] ms[6] = '{17'h12903, 17'h12904, 17'h12910, 17'h12920, 17'h0, 17'h12904};
   always #10 clock_i = ~clock_i;
   its_command_error_reporting i_its_command_error_reporting (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .apb_i(req), .apb_o(rsp), .event_i(ev_w), .map_i(map_w), .stall_o(stall), .record_valid_o(rec_valid),
      .drop_o(drop));
   its_err_partner i_its_err_partner (.clock_i(clock_i), .event_o(ev_w), .map_o(map_w));
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clock_i);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clock_i);
      req.penable <= 1'b1;
      do begin
         @(posedge clock_i);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      q = rsp.prdata;
      er = rsp.pslverr;
      req <= '0;
      if (n >= 20) bad_count++;
   endtask
   task automatic rec(input logic [16:0] s, input logic [63:0] x, input logic [3:0] st);
      apb(0, OFF_STATUS, 0);
      `CHK(q[3:0], st)
      apb(0, OFF_SYNDROME, 0);
      `CHK(q[16:0], s)
      apb(0, OFF_EXTRA_LO, 0);
      `CHK(q, x[31:0])
      apb(0, OFF_EXTRA_HI, 0);
      `CHK(q, x[63:32])
      apb(1, OFF_STATUS, 32'h9);
   endtask
   function automatic trans_event_t mk(input int k, input logic db);
      logic [191:0] r;
      trans_event_t t;
      r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      t = r[$bits(t)-1:0];
      t.valid = 1'b1;
      t.kind = err_kind_t'(k);
      t.from_doorbell = db;
      return t;
   endfunction
   // Expected extra word; gated kinds record nothing when stalled or raised by command.
   function automatic logic [63:0] xw(input trans_event_t e, input logic stl);
      logic [63:0] v;
      case (e.kind)
         5'h00: v = 64'(e.virtual_pe_identifier);
         5'h01: v = 64'(e.device_identifier);
         5'h02: v = 64'(e.device_identifier[23:0]);
         5'h03, 5'h04: v = 64'({|e.event_identifier[31:20], 6'h0, e.event_identifier[19:0],
            e.device_identifier[23:0]});
         5'h05: v = 64'(e.collection_id);
         5'h06, 5'h07: v = 64'(e.redistributor);
         5'h08: v = 64'(e.physical_id);
         5'h09, 5'h0c, 5'h0d: v = 64'({e.chip_number, e.virtual_interrupt_bits, e.virtual_pe_identifier});
         default: v = 64'({e.virtual_interrupt_bits, e.virtual_pe_identifier});
      endcase
      if (e.kind inside {[1:5]} && (stl || !e.from_doorbell)) v = '0;
      return v;
   endfunction
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      #200000;
      bad_count++;
      conclude();
   end
   initial begin
      repeat (12) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      apb(0, OFF_CTRL, 0);
      `CHK(q[1:0], 2'h1)
      apb(0, OFF_VPE_LIMIT, 0);
      `CHK(q[15:0], 16'hffff)
      apb(0, 12'h018, 0);
      `CHK(er, 1'b1)
      $display("reset test done");
      for (int k = 0; k < 15; k++) begin
         ev = mk(k, 1'b1);
         i_its_err_partner.send(ev, '0);
         #1 `CHK(drop, 1'(k == 8))
         `CHK(stall, 1'b0)
         rec(syn[k], xw(ev, 1'b0), {2'b0, 1'(k == 0 || k > 5), 1'b1});
      end
      $display("event kinds test done");
      for (int j = 0; j < 3; j++) begin
         apb(1, OFF_CTRL, {30'h0, 1'(j == 1), 1'(j != 2)});
         ev = mk(j == 0 ? 3 : j == 1 ? 1 : 4, 1'(j != 0));
         i_its_err_partner.send(ev, '0);
         #1 `CHK(stall, 1'(j == 1))
         if (j == 2) `CHK(rec_valid, 1'b0)
         else rec(syn[ev.kind], xw(ev, 1'(j == 1)), {1'b0, 1'(j == 1), 2'b01});
      end
      apb(1, OFF_CTRL, 32'h1);
      $display("gating test done");
      apb(1, OFF_VPE_LIMIT, 32'h10);
      for (int j = 0; j < 6; j++) begin
         i_its_err_partner.send('0, '{1'b1, mv[j], md[j], mt[j], mr[j]});
         #1 `CHK(stall, 1'(j < 3 || j == 5))
         if (j == 4) `CHK(rec_valid, 1'b0)
         else rec(ms[j], 64'h0, {1'b0, 1'(j != 3), 1'(j == 3), 1'b1});
      end
      $display("map command test done");
      ev = mk(6, 1'b1);
      i_its_err_partner.send(ev, '0);
      i_its_err_partner.send(mk(7, 1'b1), '0);
      rec(syn[6], xw(ev, 1'b0), 4'hb);
      $display("overflow test done");
      conclude();
   end
endmodule
